// ===== shared/pimc_pkg.sv
/*
  Constants, carrier types and the mode enum of the front-panel
  indication and mode-control block.
  Assumes a 40 MHz system clock and debounced-by-us raw panel switches.
*/
package pimc_pkg;

  // Register byte addresses and bit positions.
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h04;
  localparam int CTRL_INIT_DONE = 0;
  localparam int CTRL_CLR_E5 = 1;
  localparam int CTRL_INIT_PROT = 2;
  localparam int STAT_PROT = 0;
  localparam int STAT_AUTO = 1;
  localparam int STAT_E5 = 2;
  localparam int STAT_SEQ = 3;
  localparam int STAT_BUSY = 4;
  localparam logic [2:0] CTRL_RESET = 3'h0;

  // Timing: clock period and the millisecond tick derived from it.
  localparam int CLK_PERIOD_NS = 25;
  localparam int TICK_NS = 1000000;
  localparam int TICK_CYC = TICK_NS / CLK_PERIOD_NS;
  localparam int DEBOUNCE_MS = 20;
  localparam int LONG_PRESS_MS = 5000;
  localparam int RELEASE_MS = 1000;
  localparam int STEP_MS = 1000;
  localparam int SWITCH_MS = 500;

  // Digit encodings on the segment outputs.
  localparam logic [3:0] DIG_EIGHT = 4'h8;
  localparam logic [3:0] DIG_E = 4'hE;
  localparam logic [3:0] DIG_BLANK = 4'hF;
  localparam int CODE_E5 = 5;
  localparam int CODE_UNUSED = 4;

  typedef enum logic [2:0] {
    MODE_INIT,
    MODE_CONFIG,
    MODE_SW_PROT,
    MODE_SW_CFG,
    MODE_PROT
  } pimc_mode_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } pimc_apb_req_t;

  typedef struct packed {
    logic power_on_lamp;
    logic general_error_lamp;
    logic link_ready_lamp;
    logic host_link_alarm_lamp;
    logic auto_address_lamp;
    logic config_mode_lamp;
    logic network_supply_fault_lamp;
    logic configuration_error_lamp;
  } pimc_lamps_t;

  typedef struct packed {
    logic blank;
    logic [3:0] tens_digit;
    logic [3:0] units_digit;
    logic tens_dot;
    logic units_dot;
  } pimc_seg_t;

endpackage : pimc_pkg

// ===== design/pimc_panel.sv
/*
  Front-panel lamps, two-digit segment display and SET/display switch
  mode control, with a small APB register slave.
  Assumes synchronous inputs, slave lists indexed 0-31 for standard or
  A slaves and 32-63 for B slaves, and a mismatch list computed outside.
*/
// The register addresses and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module pimc_panel #(
  parameter int TICK_CYC = pimc_pkg::TICK_CYC
) (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire pimc_pkg::pimc_apb_req_t apb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic link_ready_i,
  input wire logic link_alarm_i,
  input wire logic supply_low_i,
  input wire logic [9:0] fault_i,
  input wire logic [63:0] detected_slave_list_i,
  input wire logic [63:0] mismatch_list_i,
  input wire logic display_request_switch_i,
  input wire logic set_switch_i,
  output pimc_pkg::pimc_lamps_t lamps_o,
  output pimc_pkg::pimc_seg_t seg_o,
  output logic store_cfg_o
);

  generate
    if (TICK_CYC < 2 || TICK_CYC > 65536)
    begin : g_bad_tick
      $error("TICK_CYC out of range");
    end
  endgenerate

  // Returns the first set index at or above from; bit 6 set means none.
  function automatic logic [6:0] find_next(input logic [63:0] l, input logic [6:0] from);
    logic [6:0] r;
    r = 7'h40;
    for (int i = 63; i >= 0; i--)
    begin
      if (l[i] && 7'(i) >= from)
        r = 7'(i);
    end
    return r;
  endfunction : find_next

  // Decimal split of a 5-bit address onto the two digits.
  function automatic pimc_pkg::pimc_seg_t show_addr(input logic [5:0] idx);
    pimc_pkg::pimc_seg_t s;
    s = '0;
    s.tens_digit = 4'(idx[4:0] / 5'h0A);
    s.units_digit = 4'(idx[4:0] % 5'h0A);
    s.units_dot = idx[5];
    return s;
  endfunction : show_addr

  logic [15:0] tick_cnt_r, tick_cnt_nxt;
  logic tick;
  logic [1:0] deb_r, deb_nxt, deb_q_r;
  logic [4:0] deb_cnt_r [2];
  logic [4:0] deb_cnt_nxt [2];
  logic [1:0] sw_raw;
  logic request_rise, set_fall;

  assign tick = (tick_cnt_r == 16'(TICK_CYC - 1));
  assign sw_raw = {set_switch_i, display_request_switch_i};
  assign request_rise = deb_r[0] & ~deb_q_r[0];

  // Millisecond tick and switch debounce; a level must hold for the full
  // debounce time before it is believed, which costs that much latency.
  always_comb
  begin
    tick_cnt_nxt = tick ? 16'h0000 : tick_cnt_r + 16'h0001;
    deb_nxt = deb_r;
    for (int i = 0; i < 2; i++)
    begin
      deb_cnt_nxt[i] = deb_cnt_r[i];
      if (sw_raw[i] == deb_r[i])
        deb_cnt_nxt[i] = 5'h00;
      else if (tick && deb_cnt_r[i] == 5'(pimc_pkg::DEBOUNCE_MS - 1))
      begin
        deb_nxt[i] = sw_raw[i];
        deb_cnt_nxt[i] = 5'h00;
      end
      else if (tick)
        deb_cnt_nxt[i] = deb_cnt_r[i] + 5'h01;
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      tick_cnt_r <= 16'h0000;
      deb_r <= 2'h0;
      deb_q_r <= 2'h0;
      deb_cnt_r[0] <= 5'h00;
      deb_cnt_r[1] <= 5'h00;
    end
    else
    begin
      tick_cnt_r <= tick_cnt_nxt;
      deb_r <= deb_nxt;
      deb_q_r <= deb_r;
      deb_cnt_r <= deb_cnt_nxt;
    end
  end

  logic [2:0] ctrl_r, ctrl_nxt;
  logic clr_e5;
  logic apb_wr, apb_setup;

  pimc_pkg::pimc_mode_t mode_r, mode_nxt;
  logic [12:0] hold_r, hold_nxt;
  logic [9:0] rel_r, rel_nxt;
  logic [9:0] swc_r, swc_nxt;
  logic armed_r, armed_nxt, auto_r, auto_nxt, e5_r, e5_nxt, store_nxt;
  logic long_press, short_press, set_act;

  assign set_fall = ~deb_r[1] & deb_q_r[1];
  assign long_press = armed_r & deb_r[1] & tick
    & (hold_r == 13'(pimc_pkg::LONG_PRESS_MS - 1));
  assign short_press = armed_r & set_fall;
  assign set_act = long_press | short_press;

  // SET switch timing and mode machine. Arming needs one second released,
  // so a switch held down can never produce a second change.
  always_comb
  begin
    mode_nxt = mode_r;
    hold_nxt = hold_r;
    rel_nxt = rel_r;
    swc_nxt = swc_r;
    armed_nxt = armed_r;
    auto_nxt = auto_r;
    e5_nxt = e5_r;
    store_nxt = 1'b0;
    if (deb_r[1])
      rel_nxt = 10'h000;
    else if (tick && rel_r != 10'(pimc_pkg::RELEASE_MS - 1))
      rel_nxt = rel_r + 10'h001;
    else if (tick)
      armed_nxt = 1'b1;
    if (armed_r && deb_r[1])
      hold_nxt = tick ? hold_r + 13'h0001 : hold_r;
    else
      hold_nxt = 13'h0000;
    if (set_act)
      armed_nxt = 1'b0;
    if (clr_e5)
      e5_nxt = 1'b0;
    case (mode_r)
      pimc_pkg::MODE_INIT:
      begin
        if (ctrl_r[pimc_pkg::CTRL_INIT_DONE])
          mode_nxt = ctrl_r[pimc_pkg::CTRL_INIT_PROT] ?
            pimc_pkg::MODE_PROT : pimc_pkg::MODE_CONFIG;
      end
      pimc_pkg::MODE_CONFIG:
      begin
        if (set_act && detected_slave_list_i[0])
          e5_nxt = 1'b1;
        else if (set_act)
        begin
          mode_nxt = pimc_pkg::MODE_SW_PROT;
          swc_nxt = 10'h000;
          store_nxt = long_press;
          auto_nxt = long_press;
        end
      end
      pimc_pkg::MODE_PROT:
      begin
        if (long_press)
        begin
          mode_nxt = pimc_pkg::MODE_SW_CFG;
          swc_nxt = 10'h000;
        end
      end
      pimc_pkg::MODE_SW_PROT, pimc_pkg::MODE_SW_CFG:
      begin
        if (tick && swc_r == 10'(pimc_pkg::SWITCH_MS - 1))
          mode_nxt = (mode_r == pimc_pkg::MODE_SW_PROT) ?
            pimc_pkg::MODE_PROT : pimc_pkg::MODE_CONFIG;
        else if (tick)
          swc_nxt = swc_r + 10'h001;
      end
      default:
        mode_nxt = pimc_pkg::MODE_INIT;
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      mode_r <= pimc_pkg::MODE_INIT;
      hold_r <= 13'h0000;
      rel_r <= 10'h000;
      swc_r <= 10'h000;
      armed_r <= 1'b0;
      auto_r <= 1'b0;
      e5_r <= 1'b0;
      store_cfg_o <= 1'b0;
    end
    else
    begin
      mode_r <= mode_nxt;
      hold_r <= hold_nxt;
      rel_r <= rel_nxt;
      swc_r <= swc_nxt;
      armed_r <= armed_nxt;
      auto_r <= auto_nxt;
      e5_r <= e5_nxt;
      store_cfg_o <= store_nxt;
    end
  end

  logic seq_r, seq_nxt;
  logic [5:0] idx_r, idx_nxt;
  logic [9:0] step_r, step_nxt;
  logic [63:0] seq_list;
  logic [6:0] f_first, f_next;
  logic in_mode;

  assign in_mode = (mode_r == pimc_pkg::MODE_CONFIG) || (mode_r == pimc_pkg::MODE_PROT);
  assign seq_list = (mode_r == pimc_pkg::MODE_PROT) ?
    mismatch_list_i : detected_slave_list_i;
  assign f_first = find_next(seq_list, 7'h00);
  assign f_next = find_next(seq_list, {1'b0, idx_r} + 7'h01);

  // Address sequence. The list is walked upward, so the A half always
  // precedes the B half; presses are ignored while a walk runs.
  always_comb
  begin
    seq_nxt = seq_r;
    idx_nxt = idx_r;
    step_nxt = step_r;
    if (!seq_r && request_rise && in_mode && !f_first[6])
    begin
      seq_nxt = 1'b1;
      idx_nxt = f_first[5:0];
      step_nxt = 10'h000;
    end
    else if (seq_r && tick && step_r == 10'(pimc_pkg::STEP_MS - 1))
    begin
      step_nxt = 10'h000;
      seq_nxt = ~f_next[6];
      idx_nxt = f_next[6] ? idx_r : f_next[5:0];
    end
    else if (seq_r && tick)
      step_nxt = step_r + 10'h001;
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      seq_r <= 1'b0;
      idx_r <= 6'h00;
      step_r <= 10'h000;
    end
    else
    begin
      seq_r <= seq_nxt;
      idx_r <= idx_nxt;
      step_r <= step_nxt;
    end
  end

  logic [9:0] faults;
  logic [3:0] code;
  logic busy88;
  logic [6:0] f_low;
  pimc_pkg::pimc_seg_t seg_nxt;
  pimc_pkg::pimc_lamps_t lamps_nxt;

  assign f_low = find_next(mismatch_list_i, 7'h00);
  assign busy88 = supply_low_i || mode_r == pimc_pkg::MODE_INIT
    || mode_r == pimc_pkg::MODE_SW_PROT || mode_r == pimc_pkg::MODE_SW_CFG;

  // Display priority: 88, then the lowest error code, then addresses.
  always_comb
  begin
    faults = fault_i;
    faults[pimc_pkg::CODE_E5] = fault_i[pimc_pkg::CODE_E5] | e5_r;
    faults[pimc_pkg::CODE_UNUSED] = 1'b0;
    code = 4'h0;
    for (int i = 9; i >= 0; i--)
    begin
      if (faults[i])
        code = 4'(i);
    end
    seg_nxt = '0;
    if (busy88)
    begin
      seg_nxt.tens_digit = pimc_pkg::DIG_EIGHT;
      seg_nxt.units_digit = pimc_pkg::DIG_EIGHT;
    end
    else if (|faults)
    begin
      seg_nxt.tens_digit = pimc_pkg::DIG_E;
      seg_nxt.units_digit = code;
    end
    else if (seq_r)
      seg_nxt = show_addr(idx_r);
    else if (mode_r == pimc_pkg::MODE_PROT && !f_low[6])
      seg_nxt = show_addr(f_low[5:0]);
    else
    begin
      seg_nxt.blank = 1'b1;
      seg_nxt.tens_digit = pimc_pkg::DIG_BLANK;
      seg_nxt.units_digit = pimc_pkg::DIG_BLANK;
    end
    lamps_nxt.power_on_lamp = 1'b1;
    lamps_nxt.general_error_lamp = (|faults) | supply_low_i;
    lamps_nxt.link_ready_lamp = link_ready_i;
    lamps_nxt.host_link_alarm_lamp = link_alarm_i;
    lamps_nxt.auto_address_lamp = (mode_r == pimc_pkg::MODE_PROT) & auto_r;
    lamps_nxt.config_mode_lamp = (mode_r == pimc_pkg::MODE_CONFIG);
    lamps_nxt.network_supply_fault_lamp = supply_low_i;
    lamps_nxt.configuration_error_lamp = |mismatch_list_i;
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      seg_o <= '0;
      lamps_o <= '0;
    end
    else
    begin
      seg_o <= seg_nxt;
      lamps_o <= lamps_nxt;
    end
  end

  logic [31:0] prdata_nxt;
  logic mapped;

  assign apb_setup = apb_i.psel & ~apb_i.penable;
  assign apb_wr = apb_i.psel & apb_i.penable & apb_i.pwrite;
  assign mapped = apb_i.paddr == pimc_pkg::ADDR_CTRL || apb_i.paddr == pimc_pkg::ADDR_STAT;
  assign clr_e5 = apb_wr && apb_i.paddr == pimc_pkg::ADDR_CTRL
    && apb_i.pwdata[pimc_pkg::CTRL_CLR_E5];
  assign pready_o = 1'b1;
  assign pslverr_o = apb_i.psel & apb_i.penable & ~mapped;

  // APB slave with no wait states; read data is captured in the setup
  // cycle so that it comes from a flip-flop during the access phase.
  always_comb
  begin
    ctrl_nxt = ctrl_r;
    prdata_nxt = prdata_o;
    if (apb_wr && apb_i.paddr == pimc_pkg::ADDR_CTRL)
    begin
      ctrl_nxt = apb_i.pwdata[2:0];
      ctrl_nxt[pimc_pkg::CTRL_CLR_E5] = 1'b0;
    end
    if (apb_setup)
    begin
      prdata_nxt = 32'h0000_0000;
      if (apb_i.paddr == pimc_pkg::ADDR_CTRL)
        prdata_nxt[2:0] = ctrl_r;
      else if (apb_i.paddr == pimc_pkg::ADDR_STAT)
      begin
        prdata_nxt[pimc_pkg::STAT_PROT] = (mode_r == pimc_pkg::MODE_PROT);
        prdata_nxt[pimc_pkg::STAT_AUTO] = auto_r;
        prdata_nxt[pimc_pkg::STAT_E5] = e5_r;
        prdata_nxt[pimc_pkg::STAT_SEQ] = seq_r;
        prdata_nxt[pimc_pkg::STAT_BUSY] = busy88;
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      ctrl_r <= pimc_pkg::CTRL_RESET;
      prdata_o <= 32'h0000_0000;
    end
    else
    begin
      ctrl_r <= ctrl_nxt;
      prdata_o <= prdata_nxt;
    end
  end

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!resetn_i);

  AST_ERR_LAMP: assert property ($past(|fault_i[3:0]) |-> lamps_o.general_error_lamp)
    else $error("general error lamp missed a fault");
  AST_RDY_LAMP: assert property (lamps_o.link_ready_lamp == $past(link_ready_i))
    else $error("link ready lamp wrong");
  AST_AUTO_LAMP: assert property (lamps_o.auto_address_lamp |-> $past(mode_r == pimc_pkg::MODE_PROT))
    else $error("auto-address lamp outside protection mode");
  AST_CM_LAMP: assert property (lamps_o.config_mode_lamp == $past(mode_r == pimc_pkg::MODE_CONFIG))
    else $error("configuration lamp wrong");
  AST_LOW_88: assert property (supply_low_i |=> seg_o.tens_digit == pimc_pkg::DIG_EIGHT
    && lamps_o.network_supply_fault_lamp)
    else $error("low supply not shown");
  AST_ZERO_REFUSE: assert property (mode_r == pimc_pkg::MODE_CONFIG && set_act
    && detected_slave_list_i[0] |=> e5_r && mode_r == pimc_pkg::MODE_CONFIG && !store_cfg_o)
    else $error("slave zero press not refused");
  AST_LONG_STORE: assert property (mode_r == pimc_pkg::MODE_CONFIG && long_press
    && !detected_slave_list_i[0] |=> store_cfg_o && auto_r ##1 !store_cfg_o)
    else $error("long press did not store once");
  AST_SHORT_NOSTORE: assert property (mode_r == pimc_pkg::MODE_CONFIG && short_press
    && !detected_slave_list_i[0] |=> !store_cfg_o && !auto_r && mode_r == pimc_pkg::MODE_SW_PROT)
    else $error("short press misbehaved");
  AST_PROT_SHORT: assert property (mode_r == pimc_pkg::MODE_PROT && short_press
    |=> mode_r == pimc_pkg::MODE_PROT)
    else $error("short press changed protection mode");
  AST_ONE_CHANGE: assert property (set_act |=> !armed_r ##1 !set_act)
    else $error("second change on one press");
  AST_B_AFTER_A: assert property (seq_r && $past(seq_r) && $past(idx_r[5]) |-> idx_r[5])
    else $error("A address after B address");
  AST_SEQ_IGNORE: assert property (seq_r && request_rise && !tick |=> $stable(idx_r))
    else $error("press disturbed running sequence");

  COV_LONG_STORE: cover property (store_cfg_o);
  COV_SEQ_RUN: cover property (seq_r ##1 !seq_r);
  COV_E5: cover property ($rose(e5_r));
  COV_BACK_CFG: cover property (mode_r == pimc_pkg::MODE_SW_CFG);

endmodule : pimc_panel

// ===== bench/pimc_operator.sv
/*
  Operator model: presses the SET and display switches for given times.
  Assumes the panel clock and that callers give press lengths in ms.
*/
`timescale 1ns/1ps
module pimc_operator #(
  parameter int TICK = 4
) (
  input wire logic clk_i,
  output logic set_o,
  output logic display_o
);
  // Both switches rest released, as a hand lifted off the panel.
  initial
  begin
    set_o = 1'b0;
    display_o = 1'b0;
  end

  // A SET press always follows a full second and more of release.
  task automatic press_set(input int ms);
    repeat (1030 * TICK) @(posedge clk_i);
    set_o <= 1'b1;
    repeat (ms * TICK) @(posedge clk_i);
    set_o <= 1'b0;
  endtask : press_set

  // The display switch has no release rule of its own.
  task automatic press_display(input int ms);
    @(posedge clk_i);
    display_o <= 1'b1;
    repeat (ms * TICK) @(posedge clk_i);
    display_o <= 1'b0;
  endtask : press_display
endmodule : pimc_operator

// ===== bench/tb.sv
/*
  Self-checking bench of the panel block: APB register tasks, lamps,
  segment codes, display sequences and SET mode changes.
  Assumes a shortened millisecond tick of four clock cycles.
*/
`timescale 1ns/1ps
module tb;
  localparam int TICK = 4;
  logic clk;
  logic rstn;
  pimc_pkg::pimc_apb_req_t apb_r;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic ready;
  logic alarm;
  logic low;
  logic [9:0] fault;
  logic [63:0] det;
  logic [63:0] mism;
  logic set_sw;
  logic display_sw;
  pimc_pkg::pimc_lamps_t lamps;
  pimc_pkg::pimc_seg_t seg;
  logic store;
  int fail_count;
  int check_count;
  int store_n;
  logic [31:0] q;
  logic e;

  pimc_panel #(.TICK_CYC(TICK)) dut (.ref_clk_i(clk), .resetn_i(rstn), .apb_i(apb_r),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .link_ready_i(ready),
    .link_alarm_i(alarm), .supply_low_i(low), .fault_i(fault),
    .detected_slave_list_i(det), .mismatch_list_i(mism),
    .display_request_switch_i(display_sw), .set_switch_i(set_sw), .lamps_o(lamps),
    .seg_o(seg), .store_cfg_o(store));

  pimc_operator #(.TICK(TICK)) op (.clk_i(clk), .set_o(set_sw), .display_o(display_sw));

  // The 40 MHz clock.
  always #12.5 clk = ~clk;

  // Store pulses are counted so that only stored-mode presses add one.
  always @(posedge clk)
    if (store === 1'b1)
      store_n++;

  // One compare, counted, reported at once on a mismatch.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    check_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask : chk

  // Compares the segment word with a lit two-digit value.
  task automatic chk_seg(input logic [3:0] t, input logic [3:0] u, input logic ud,
                         input string m);
    chk({21'h0, seg}, {21'h0, 1'b0, t, u, 1'b0, ud}, m);
  endtask : chk_seg

  // One APB transfer; the request stands until pready is seen high.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    apb_r <= '{1'b1, 1'b0, wr, a, d};
    @(posedge clk);
    apb_r.penable <= 1'b1;
    // Only the watchdog may end a wait for the answer.
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    q = prdata;
    e = pslverr;
    apb_r <= '0;
  endtask : apb

  task automatic wait_ms(input int ms);
    repeat (ms * TICK) @(posedge clk);
  endtask : wait_ms

  // Prints the counts and the verdict, then stops the run.
  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : end_of_test

  // A hang is cut short a little past the planned run length.
  initial
  begin
    repeat (98000) @(posedge clk);
    fail_count++;
    end_of_test();
  end

  // Main sequence.
  initial
  begin
    clk = 1'b0;
    rstn = 1'b0;
    apb_r = '0;
    {ready, alarm, low} = 3'h0;
    fault = 10'h000;
    det = 64'h0;
    mism = 64'h0;
    fail_count = 0;
    check_count = 0;
    store_n = 0;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    chk_seg(4'h8, 4'h8, 1'b0, "init shows 88");
    apb(1'b0, pimc_pkg::ADDR_STAT, 32'h0);
    chk(q[4:0], 5'h10, "busy in init");
    apb(1'b0, 8'h08, 32'h0);
    chk({q[3:0], e}, 5'h01, "unmapped read");
    apb(1'b1, pimc_pkg::ADDR_CTRL, 32'h1);
    // Link, supply and mismatch levels pass to their lamps, both ways.
    for (int k = 0; k < 8; k++)
    begin
      {ready, alarm, low} <= 3'(k);
      mism <= 64'(k) << 5;
      repeat (3) @(posedge clk);
      chk(lamps.power_on_lamp, 1'b1, "power lamp");
      chk(lamps.link_ready_lamp, k[2], "ready lamp");
      chk(lamps.host_link_alarm_lamp, k[1], "alarm lamp");
      chk(lamps.network_supply_fault_lamp, k[0], "supply lamp");
      chk(lamps.general_error_lamp, k[0], "error lamp on low supply");
      chk(lamps.configuration_error_lamp, k != 0, "mismatch lamp");
    end
    {ready, alarm, low} <= 3'h0;
    repeat (3) @(posedge clk);
    chk({lamps.config_mode_lamp, lamps.auto_address_lamp}, 2'h2, "config lamps");
    chk(seg.blank, 1'b1, "config idle blank");
    mism <= 64'h0;
    // Every error code, one at a time.
    foreach (fault[i])
      if (i != 4)
      begin
        fault <= 10'h001 << i;
        repeat (3) @(posedge clk);
        chk_seg(4'hE, 4'(i), 1'b0, "error code");
        chk(lamps.general_error_lamp, 1'b1, "error lamp");
      end
    fault <= 10'h000;
    low <= 1'b1;
    repeat (3) @(posedge clk);
    chk_seg(4'h8, 4'h8, 1'b0, "supply low 88");
    chk(lamps.network_supply_fault_lamp, 1'b1, "supply lamp");
    low <= 1'b0;
    // Detected list 3, 31 and B1, with a second press inside the run.
    det <= (64'h1 << 3) | (64'h1 << 31) | (64'h1 << 33);
    op.press_display(40);
    chk_seg(4'h0, 4'h3, 1'b0, "first address");
    // The release must outlast the debounce, or both presses merge into one.
    wait_ms(30);
    op.press_display(40);
    wait_ms(1000);
    chk_seg(4'h3, 4'h1, 1'b0, "second address");
    wait_ms(1000);
    chk_seg(4'h0, 4'h1, 1'b1, "B slave last");
    wait_ms(1000);
    chk(seg.blank, 1'b1, "sequence over");
    // Slave zero blocks the change and raises E5.
    det <= 64'h9;
    op.press_set(200);
    wait_ms(30);
    chk_seg(4'hE, 4'h5, 1'b0, "E5 shown");
    apb(1'b0, pimc_pkg::ADDR_STAT, 32'h0);
    chk(q[2:0], 3'h4, "stays config");
    apb(1'b1, pimc_pkg::ADDR_CTRL, 32'h3);
    det <= 64'h8;
    // Short press in configuration: protection, nothing stored.
    op.press_set(200);
    wait_ms(30);
    chk_seg(4'h8, 4'h8, 1'b0, "switching 88");
    wait_ms(500);
    apb(1'b0, pimc_pkg::ADDR_STAT, 32'h0);
    chk(q[2:0], 3'h1, "protection no auto");
    chk({lamps.config_mode_lamp, lamps.auto_address_lamp}, 2'h0, "lamps");
    chk(store_n, 0, "no store");
    // Protection: lowest mismatch idle, then the mismatch run.
    mism <= (64'h1 << 7) | (64'h1 << 34);
    repeat (3) @(posedge clk);
    chk_seg(4'h0, 4'h7, 1'b0, "lowest mismatch");
    op.press_display(40);
    wait_ms(1000);
    chk_seg(4'h0, 4'h2, 1'b1, "mismatch B2");
    wait_ms(1000);
    mism <= 64'h0;
    op.press_display(40);
    chk(seg.blank, 1'b1, "empty mismatch list");
    op.press_set(200);
    wait_ms(30);
    apb(1'b0, pimc_pkg::ADDR_STAT, 32'h0);
    chk(q[4:0], 5'h01, "short keeps mode");
    // A long hold in protection changes the mode once only.
    op.press_set(5600);
    wait_ms(30);
    apb(1'b0, pimc_pkg::ADDR_STAT, 32'h0);
    chk(q[0], 1'b0, "back to config");
    chk(lamps.config_mode_lamp, 1'b1, "one change per hold");
    // Long press in configuration stores and enables auto addressing.
    op.press_set(5100);
    wait_ms(530);
    chk(store_n, 1, "one store pulse");
    apb(1'b0, pimc_pkg::ADDR_STAT, 32'h0);
    chk(q[2:0], 3'h3, "protection with auto");
    chk(lamps.auto_address_lamp, 1'b1, "auto lamp");
    // A second reset mid-run; this time the block starts in protection mode.
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    chk_seg(4'h8, 4'h8, 1'b0, "88 after second reset");
    apb(1'b1, pimc_pkg::ADDR_CTRL, 32'h5);
    repeat (3) @(posedge clk);
    apb(1'b0, pimc_pkg::ADDR_STAT, 32'h0);
    chk(q[4:0], 5'h01, "init into protection");
    chk({lamps.config_mode_lamp, lamps.auto_address_lamp}, 2'h0, "auto cleared");
    end_of_test();
  end
endmodule : tb
